// ===== common/icr_pkg.sv
// constants, register map and carrier types of the two-wire configuration block
// assumes a classic wishbone slave with 32-bit data, one byte register per word
package icr_pkg;
    localparam int unsigned ICR_CLK_HZ = 100_000_000;
    localparam int unsigned ICR_ADDR_W = 8;
    // word offsets of the byte registers (byte address = 4 * index)
    localparam logic [7:0] ICR_IDX_CTRL = 8'hf0;
    localparam logic [7:0] ICR_IDX_CCR = 8'hf3;
    localparam logic [7:0] ICR_IDX_OAL = 8'hf4;
    localparam logic [7:0] ICR_IDX_OAH = 8'hf5;
    localparam logic [7:0] ICR_IDX_DATA = 8'hf6;
    localparam logic [7:0] ICR_IDX_GCA = 8'hf7;
    localparam logic [7:0] ICR_IDX_ISR = 8'hf8;
    localparam logic [7:0] ICR_IDX_IVR = 8'hf9;
    localparam logic [7:0] ICR_IDX_RDAP = 8'hfa;
    localparam logic [7:0] ICR_IDX_ECCR = 8'hfe;
    localparam logic [7:0] ICR_IDX_FLAGS = 8'he0;
    // reset values
    localparam logic [7:0] ICR_RST_ZERO = 8'h00;
    localparam logic [7:0] ICR_RST_GCA = 8'ha0;
    localparam logic [7:0] ICR_RST_ISR = 8'h80;
    // writable masks
    localparam logic [7:0] ICR_OAH_ADDR_MASK = 8'h06;
    localparam logic [7:0] ICR_OAH_LOCK_MASK = 8'hf0;
    localparam logic [7:0] ICR_OAH_RANGE_MASK = 8'hd0;
    localparam logic [7:0] ICR_OAH_TEN_MASK = 8'h20;
    localparam logic [7:0] ICR_ISR_CFG_MASK = 8'hf0;
    localparam logic [7:0] ICR_ECCR_MASK = 8'h03;
    localparam logic [7:0] ICR_IVR_BASE_MASK = 8'hf8;
    localparam logic [7:0] ICR_CTRL_MASK = 8'h21;
    localparam logic [7:0] ICR_NEVER_ADDR = 8'h01;
    // field positions
    localparam int unsigned ICR_B_FAST = 7;
    localparam int unsigned ICR_B_PE = 5;
    localparam int unsigned ICR_B_ITE = 0;
    localparam int unsigned ICR_B_TEN = 5;
    localparam int unsigned ICR_B_SUSP = 7;
    localparam int unsigned ICR_B_ERRP = 2;
    localparam int unsigned ICR_B_RXP = 1;
    localparam int unsigned ICR_B_TXP = 0;
    localparam int unsigned ICR_NUM_FLAGS = 8;
    localparam logic [2:0] ICR_PRIO_NONE = 3'h7;
    // source codes of the vector
    localparam logic [1:0] ICR_EV_NONE = 2'h0;
    localparam logic [1:0] ICR_EV_ERR = 2'h1;
    localparam logic [1:0] ICR_EV_RX = 2'h2;
    localparam logic [1:0] ICR_EV_TX = 2'h3;

    typedef enum logic [2:0] {
        ICR_SRC_NONE = 3'b000,
        ICR_SRC_ERR_HI = 3'b001,
        ICR_SRC_RX_DMA = 3'b010,
        ICR_SRC_TX_DMA = 3'b011,
        ICR_SRC_ERR_LO = 3'b100,
        ICR_SRC_RX = 3'b101,
        ICR_SRC_TX = 3'b110
    } icr_src_t;

    typedef struct packed {
        logic [8:0] divider;
        logic fast;
        logic [2:0] range_code;
        logic ten_bit;
        logic [9:0] own_addr;
        logic [7:0] gc_addr;
    } icr_cfg_t;

    typedef struct packed {
        logic rx_dma_req;
        logic tx_dma_req;
        logic irq_req;
        logic [2:0] prio;
        icr_src_t src;
    } icr_req_t;
endpackage

// ===== hdl/icr_regs.sv
// configuration, address, data, pending and vector registers of the two-wire interface
// assumes a classic wishbone master; the serial engine and dma controller sit alongside
`timescale 1ns/1ps
`default_nettype none
module icr_regs
    import icr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ICR_ADDR_W+1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [ICR_NUM_FLAGS-1:0] error_flags_in,
    input wire logic rx_byte_in,
    input wire logic [7:0] rx_data_in,
    input wire logic tx_ready_in,
    input wire logic rx_dma_want_in,
    input wire logic tx_dma_want_in,
    input wire logic rx_dma_done_in,
    input wire logic tx_dma_done_in,
    input wire logic [7:0] addr_byte_in,
    input wire logic addr_valid_in,
    output logic address_matched_out,
    output logic tx_start_out,
    output logic [7:0] tx_data_out,
    output logic rx_resume_out,
    output icr_cfg_t cfg_out,
    output icr_req_t req_out
);
    logic [7:0] ctrl, ccr, eccr, oal, oah, data, gca, interrupt_segment_reg, ivr, rdap;
    logic [ICR_NUM_FLAGS-1:0] flag_s1, flag_s2;
    logic busy_ack;

    // decode
    wire acc = wb_cyc_in && wb_stb_in && !busy_ack;
    wire [7:0] idx = wb_adr_in[ICR_ADDR_W+1:2];
    wire wr = acc && wb_we_in && wb_sel_in[0];
    wire rd = acc && !wb_we_in;
    wire [7:0] wd = wb_dat_in[7:0];
    wire pe = ctrl[ICR_B_PE];
    wire interface_irq_enable = ctrl[ICR_B_ITE];
    wire any_flag = |flag_s2;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv, input logic [7:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction

    // locked fields take the write only while disabled
    wire [7:0] oah_mask = ICR_OAH_ADDR_MASK | (pe ? ICR_RST_ZERO : ICR_OAH_LOCK_MASK);
    wire [7:0] next_oah = merge(oah, wd, oah_mask);

    // pending bits: write one ignored, write zero clears, event wins over clear
    wire isr_wr = wr && (idx == ICR_IDX_ISR);
    wire next_errp = (interface_irq_enable && any_flag) || (interrupt_segment_reg[ICR_B_ERRP] && !(isr_wr && !wd[ICR_B_ERRP]));
    wire next_rxp = (interface_irq_enable && rx_byte_in) || (interrupt_segment_reg[ICR_B_RXP] && !(isr_wr && !wd[ICR_B_RXP]));
    wire next_txp = (interface_irq_enable && tx_ready_in) || (interrupt_segment_reg[ICR_B_TXP] && !(isr_wr && !wd[ICR_B_TXP]));
    wire [7:0] next_isr = {isr_wr ? wd[7:4] : interrupt_segment_reg[7:4], 1'b0, next_errp, next_rxp, next_txp};

    // fixed source order
    wire susp = interrupt_segment_reg[ICR_B_SUSP];
    wire dma_block = susp && interrupt_segment_reg[ICR_B_ERRP];
    wire prio_on = interrupt_segment_reg[6:4] != ICR_PRIO_NONE;
    wire src_err_hi = susp && interrupt_segment_reg[ICR_B_ERRP];
    wire src_rxd = rx_dma_want_in && !dma_block;
    wire src_txd = tx_dma_want_in && !dma_block;
    wire src_err_lo = !susp && interrupt_segment_reg[ICR_B_ERRP];
    wire src_rx = interrupt_segment_reg[ICR_B_RXP];
    wire src_tx = interrupt_segment_reg[ICR_B_TXP];
    icr_src_t next_src;
    assign next_src = !prio_on ? ICR_SRC_NONE :
        src_err_hi ? ICR_SRC_ERR_HI :
        src_rxd ? ICR_SRC_RX_DMA :
        src_txd ? ICR_SRC_TX_DMA :
        src_err_lo ? ICR_SRC_ERR_LO :
        src_rx ? ICR_SRC_RX :
        src_tx ? ICR_SRC_TX : ICR_SRC_NONE;
    logic [1:0] next_ev;
    always_comb begin
        unique case (next_src)
            ICR_SRC_ERR_HI, ICR_SRC_ERR_LO: next_ev = ICR_EV_ERR;
            ICR_SRC_RX: next_ev = ICR_EV_RX;
            ICR_SRC_TX: next_ev = ICR_EV_TX;
            default: next_ev = ivr[2:1];
        endcase
    end

    // address comparison
    wire ten = oah[ICR_B_TEN];
    wire [9:0] own10 = {oah[2:1], oal};
    wire match7 = (addr_byte_in[7:1] == oal[7:1]) && (addr_byte_in != ICR_NEVER_ADDR);
    wire match10 = ({addr_byte_in[2:1], oal} == own10);
    wire match_gc = (addr_byte_in[7:1] == gca[7:1]) && (addr_byte_in != ICR_NEVER_ADDR);
    wire next_match = addr_valid_in && pe && ((ten ? match10 : match7) || match_gc);

    logic [7:0] rdata;
    always_comb begin
        unique case (idx)
            ICR_IDX_CTRL: rdata = ctrl;
            ICR_IDX_CCR: rdata = ccr;
            ICR_IDX_ECCR: rdata = eccr;
            ICR_IDX_OAL: rdata = oal;
            ICR_IDX_OAH: rdata = oah;
            ICR_IDX_DATA: rdata = data;
            ICR_IDX_GCA: rdata = gca;
            ICR_IDX_ISR: rdata = interrupt_segment_reg;
            ICR_IDX_IVR: rdata = ivr;
            ICR_IDX_RDAP: rdata = rdap;
            ICR_IDX_FLAGS: rdata = flag_s2;
            default: rdata = ICR_RST_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        flag_s1 <= error_flags_in;
        flag_s2 <= flag_s1;
    end

    // bus slave: ack one cycle after request, released next cycle
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            busy_ack <= 1'b0;
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            busy_ack <= acc;
            wb_ack_out <= acc;
            wb_dat_out <= acc ? {24'h000000, rdata} : '0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctrl <= ICR_RST_ZERO;
            ccr <= ICR_RST_ZERO;
            eccr <= ICR_RST_ZERO;
            oal <= ICR_RST_ZERO;
            oah <= ICR_RST_ZERO;
            gca <= ICR_RST_GCA;
            rdap <= ICR_RST_ZERO;
        end else if (wr) begin
            if (idx == ICR_IDX_CTRL) ctrl <= wd & ICR_CTRL_MASK;
            if (idx == ICR_IDX_CCR) ccr <= wd;
            if (idx == ICR_IDX_ECCR) eccr <= wd & ICR_ECCR_MASK;
            if (idx == ICR_IDX_OAL) oal <= wd;
            if (idx == ICR_IDX_OAH) oah <= next_oah;
            if (idx == ICR_IDX_GCA && !pe) gca <= wd;
            if (idx == ICR_IDX_RDAP) rdap <= wd;
        end
    end

    // data buffer and hand-off pulses
    wire data_wr = wr && (idx == ICR_IDX_DATA);
    wire data_rd = rd && (idx == ICR_IDX_DATA);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            data <= ICR_RST_ZERO;
            tx_start_out <= 1'b0;
            rx_resume_out <= 1'b0;
            tx_data_out <= ICR_RST_ZERO;
        end else begin
            if (data_wr) data <= wd;
            else if (rx_byte_in) data <= rx_data_in;
            tx_start_out <= data_wr || tx_dma_done_in;
            rx_resume_out <= data_rd || rx_dma_done_in;
            tx_data_out <= data_wr ? wd : data;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            interrupt_segment_reg <= ICR_RST_ISR;
            ivr <= ICR_RST_ZERO;
            req_out <= '0;
            address_matched_out <= 1'b0;
            cfg_out <= '0;
        end else begin
            interrupt_segment_reg <= next_isr;
            ivr <= {(wr && idx == ICR_IDX_IVR) ? wd[7:3] : ivr[7:3], next_ev, 1'b0};
            req_out.rx_dma_req <= src_rxd;
            req_out.tx_dma_req <= src_txd;
            req_out.irq_req <= interface_irq_enable && (src_err_hi || src_err_lo || src_rx || src_tx);
            req_out.prio <= interrupt_segment_reg[6:4];
            req_out.src <= next_src;
            address_matched_out <= next_match;
            cfg_out.divider <= {eccr[1:0], ccr[6:0]};
            cfg_out.fast <= ccr[ICR_B_FAST];
            cfg_out.range_code <= {oah[4], oah[7:6]};
            cfg_out.ten_bit <= ten;
            cfg_out.own_addr <= own10;
            cfg_out.gc_addr <= gca;
        end
    end

    chk_err_holds: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (interface_irq_enable && any_flag) |=> interrupt_segment_reg[ICR_B_ERRP]) else $error("error pending not held");
    chk_gca_locked: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        pe |=> $stable(gca)) else $error("general call address changed while enabled");
    chk_dma_suspend: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (susp && interrupt_segment_reg[ICR_B_ERRP]) |=> !req_out.rx_dma_req && !req_out.tx_dma_req) else $error("dma not suspended");
    chk_range_lock: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(pe) |-> oah[7:4] == $past(oah[7:4])) else $error("range code changed while enabled");
    chk_vec_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !ivr[0]) else $error("vector bit zero set");
    chk_tx_start: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        data_wr |=> tx_start_out) else $error("tx start missing");
    chk_rx_pend: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (!interface_irq_enable && !interrupt_segment_reg[ICR_B_RXP]) |=> !interrupt_segment_reg[ICR_B_RXP]) else $error("rx pending set without enable");
    chk_no_prio: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (interrupt_segment_reg[6:4] == ICR_PRIO_NONE) |=> req_out.src == ICR_SRC_NONE) else $error("source with no priority");
endmodule
`default_nettype wire

// ===== tb/icr_engine_model.sv
// far-side model: serial engine and dma events seen by the register block
// assumes one bench process calls its tasks, each starting after a clock edge
`timescale 1ns/1ps
`default_nettype none
module icr_engine_model (
    input wire logic clk_in,
    output logic [7:0] flags_out,
    output logic rx_byte_out,
    output logic [7:0] rx_data_out,
    output logic tx_ready_out,
    output logic rx_want_out,
    output logic tx_want_out,
    output logic rx_done_out,
    output logic tx_done_out,
    output logic [7:0] addr_out,
    output logic addr_valid_out
);
    logic [2:0] st = 3'b000;
    initial begin
        flags_out = 8'h00;
        rx_byte_out = 1'b0;
        rx_data_out = 8'h5a;
        {rx_want_out, tx_want_out, addr_valid_out} = 3'b000;
        addr_out = 8'ha5;
    end
    assign tx_ready_out = st[0];
    assign rx_done_out = st[1];
    assign tx_done_out = st[2];
    // stale data is inverted so a late sample never passes by luck
    task automatic rx(input logic [7:0] d);
        @(posedge clk_in);
        rx_data_out <= d;
        rx_byte_out <= 1'b1;
        @(posedge clk_in);
        rx_byte_out <= 1'b0;
        rx_data_out <= ~d;
    endtask
    // 0 tx ready, 1 rx dma done, 2 tx dma done
    task automatic strobe(input int s);
        @(posedge clk_in);
        st <= 3'b001 << s;
        @(posedge clk_in);
        st <= 3'b000;
    endtask
    task automatic addr(input logic [7:0] b);
        @(posedge clk_in);
        addr_out <= b;
        addr_valid_out <= 1'b1;
        @(posedge clk_in);
        addr_valid_out <= 1'b0;
        addr_out <= ~b;
    endtask
    task automatic level(input logic [7:0] f, input logic rw, input logic tw);
        @(posedge clk_in);
        flags_out <= f;
        rx_want_out <= rw;
        tx_want_out <= tw;
    endtask
endmodule
`default_nettype wire

// ===== tb/icr_regs_test.sv
// self-checking bench of the two-wire register block
// assumes the engine model drives the serial and dma events
`timescale 1ns/1ps
`default_nettype none
module icr_regs_test;
    import icr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic [3:0] sel = 4'h1;
    int r0 = 0;
    logic ack, mat, txs, rxr, rxb, txr, rdw, tdw, rdd, tdd, av;
    logic [7:0] txd, flg, rxd, ab, q;
    icr_cfg_t cfg;
    icr_req_t req;
    logic [7:0] m [256];
    logic [7:0] regs [11] = '{8'hf0, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfe, 8'h10};
    int fail_count = 0, n_compared = 0, seed = 32'h6ad1, n_tx = 0, n_rx = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (txs === 1'b1) n_tx <= n_tx + 1;
    always @(posedge clk) if (rxr === 1'b1) n_rx <= n_rx + 1;
    icr_regs i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .error_flags_in(flg), .rx_byte_in(rxb), .rx_data_in(rxd), .tx_ready_in(txr), .rx_dma_want_in(rdw),
        .tx_dma_want_in(tdw), .rx_dma_done_in(rdd), .tx_dma_done_in(tdd), .addr_byte_in(ab),
        .addr_valid_in(av), .address_matched_out(mat), .tx_start_out(txs), .tx_data_out(txd),
        .rx_resume_out(rxr), .cfg_out(cfg), .req_out(req));
    icr_engine_model i_eng (.clk_in(clk), .flags_out(flg), .rx_byte_out(rxb), .rx_data_out(rxd),
        .tx_ready_out(txr), .rx_want_out(rdw), .tx_want_out(tdw), .rx_done_out(rdd), .tx_done_out(tdd),
        .addr_out(ab), .addr_valid_out(av));
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ack and read data taken at the rising edge that samples ack high
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i);
        wb(1'b0, i, 8'h00);
        chk($sformatf("reg %h", i), m[i], q);
        chk("upper bits", 16'h0, rdat[23:8]);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic pe;
        pe = m[8'hf0][5];
        wb(1'b1, i, d);
        case (i)
            8'hf0: m[i] = d & 8'h21;
            8'hf5: m[i] = pe ? {m[i][7:4], 1'b0, d[2:1], 1'b0} : d & 8'hf6;
            8'hf7: if (!pe) m[i] = d;
            8'hf8: m[i] = {d[7:4], 1'b0, m[i][2:0] & d[2:0]};
            8'hf9: m[i] = {d[7:3], m[i][2:0]};
            8'hfe: m[i] = d & 8'h03;
            8'hf3, 8'hf4, 8'hf6, 8'hfa: m[i] = d;
            default: ;
        endcase
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report();
    end
    initial begin
        foreach (m[k]) m[k] = 8'h00;
        m[8'hf7] = 8'ha0;
        m[8'hf8] = 8'h80;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[k]) rd(regs[k]);
        $display("test reset done");
        wr(8'hf3, 8'($random(seed)));
        wr(8'hfe, 8'hff);
        wr(8'hf4, 8'($random(seed)));
        wr(8'hf5, 8'h66);
        wr(8'hf7, 8'h00);
        wr(8'hfa, 8'($random(seed)));
        wr(8'hf0, 8'h20);
        wr(8'hf5, 8'h9a);
        wr(8'hf7, 8'h42);
        wr(8'hf0, 8'h00);
        foreach (regs[k]) rd(regs[k]);
        chk("divider", {m[8'hfe][1:0], m[8'hf3][6:0]}, cfg.divider);
        chk("fast", m[8'hf3][7], cfg.fast);
        chk("range", {m[8'hf5][4], m[8'hf5][7:6]}, cfg.range_code);
        chk("ten bit", m[8'hf5][5], cfg.ten_bit);
        chk("own addr", {m[8'hf5][2:1], m[8'hf4]}, cfg.own_addr);
        chk("gc addr", m[8'hf7], cfg.gc_addr);
        sel <= 4'h0;
        wb(1'b1, 8'hfa, 8'h3c);
        sel <= 4'h1;
        rd(8'hfa);
        $display("test config done");
        wr(8'hf5, 8'h40);
        wr(8'hf4, 8'h54);
        wr(8'hf0, 8'h20);
        i_eng.addr(8'h55);
        @(negedge clk);
        chk("match", 16'h1, mat);
        i_eng.addr(8'h56);
        @(negedge clk);
        chk("match", 16'h0, mat);
        wr(8'hf4, 8'h00);
        i_eng.addr(8'h01);
        @(negedge clk);
        chk("match", 16'h0, mat);
        wr(8'hf0, 8'h00);
        $display("test address done");
        wr(8'hf6, 8'hc3);
        repeat (3) @(posedge clk);
        chk("tx starts", 16'd1, n_tx);
        chk("tx data", 16'hc3, txd);
        i_eng.strobe(2);
        repeat (3) @(posedge clk);
        chk("tx starts", 16'd2, n_tx);
        r0 = n_rx;
        i_eng.rx(8'h3c);
        m[8'hf6] = 8'h3c;
        rd(8'hf6);
        i_eng.strobe(1);
        repeat (3) @(posedge clk);
        chk("rx resumes", 16'd2, 16'(n_rx - r0));
        $display("test data done");
        wr(8'hf9, 8'ha8);
        wr(8'hf0, 8'h01);
        wr(8'hf8, 8'hb7);
        i_eng.rx(8'h81);
        i_eng.strobe(0);
        m[8'hf6] = 8'h81;
        m[8'hf8][1:0] = 2'b11;
        m[8'hf9][2:1] = ICR_EV_RX;
        rd(8'hf8);
        rd(8'hf9);
        wr(8'hf8, 8'hb5);
        m[8'hf9][2:1] = ICR_EV_TX;
        rd(8'hf8);
        rd(8'hf9);
        i_eng.level(8'h04, 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        wr(8'hf8, 8'hb3);
        m[8'hf8][2] = 1'b1;
        m[8'hf9][2:1] = ICR_EV_ERR;
        rd(8'hf8);
        rd(8'hf9);
        chk("rx dma", 16'h0, req.rx_dma_req);
        chk("source", ICR_SRC_ERR_HI, req.src);
        chk("prio", 16'h3, req.prio);
        wr(8'hf8, 8'h37);
        @(negedge clk);
        chk("rx dma", 16'h1, req.rx_dma_req);
        chk("source", ICR_SRC_RX_DMA, req.src);
        i_eng.level(8'h00, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        chk("source", ICR_SRC_TX_DMA, req.src);
        wr(8'hf8, 8'h33);
        rd(8'hf8);
        i_eng.level(8'h00, 1'b0, 1'b0);
        wr(8'hf0, 8'h00);
        i_eng.rx(8'h18);
        m[8'hf6] = 8'h18;
        rd(8'hf8);
        wr(8'hf8, 8'h70);
        repeat (2) @(negedge clk);
        chk("no prio source", ICR_SRC_NONE, req.src);
        rd(8'hf8);
        $display("test pending done");
        final_report();
    end
endmodule
`default_nettype wire
